// *** logic/lpf_pkg.sv ***
// Shared constants for the transceiver fault status and interrupt block.
// Assumes a 50 MHz system clock and a byte-addressed 32-bit register bus.
`default_nettype none

package lpf_pkg;

   // Register byte offsets
   localparam logic [4:0] OFS_TEST     = 5'h00;
   localparam logic [4:0] OFS_STATUS   = 5'h04;
   localparam logic [4:0] OFS_IRQ_EN   = 5'h08;
   localparam logic [4:0] OFS_FLAGS    = 5'h0C;
   localparam logic [4:0] OFS_CTRL     = 5'h10;
   localparam logic [4:0] OFS_FLAG_CLR = 5'h14;

   // Field positions
   localparam int BIT_DOM    = 7;  // Dominant timeout flag, enable and stuck status
   localparam int BIT_OC     = 6;  // Overcurrent flag and enable
   localparam int BIT_ENABLE = 3;  // Unit enable in the control register
   localparam int BIT_RXONLY = 2;  // Receive-only in the control register

   // Values after reset
   localparam logic [7:0] TEST_RST   = 8'h00;
   localparam logic [1:0] IRQ_EN_RST = 2'h0;
   localparam logic       ENABLE_RST = 1'b0;
   localparam logic       RXONLY_RST = 1'b0;

   // Timing, times in ns, counts rounded up to whole cycles
   localparam int CLK_PERIOD_NS  = 20;
   localparam int DOM_TIMEOUT_NS = 8000000;
   localparam int OC_MASK_NS     = 15000;
   localparam int BIT_TIME_NS    = 52000;
   localparam int DOM_TIMEOUT_CYC = (DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OC_MASK_CYC     = (OC_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BIT_TIME_CYC    = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int TMR_W = 20;  // Wide enough for the dominant timeout

   typedef enum logic {BUS_IDLE, BUS_ANSWER} lpf_bus_state_e;

endpackage

`default_nettype wire

// *** logic/lpf_cycle_timer.sv ***
// Saturating cycle timer: counts while run is high, restarts when it drops.
// Assumes run is synchronous to clk; done is combinational from the count.
`default_nettype none

module lpf_cycle_timer
   import lpf_pkg::*;
#(
   parameter int unsigned LIMIT = 1
) (
   input  wire logic clk,    // System clock
   input  wire logic reset,  // Synchronous reset, active high
   input  wire logic ce,     // Clock enable, freezes the count when low
   input  wire logic run,    // Condition being timed
   output logic      done    // Condition has held for LIMIT cycles
);

   logic [TMR_W-1:0] cnt_q;

   // Count stops at the limit so it never wraps during a long fault
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (!run) begin
            cnt_q <= '0;
         end else if (!done) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   assign done = run && (cnt_q >= LIMIT[TMR_W-1:0]);

endmodule

`default_nettype wire

// *** logic/lpf_fault_irq.sv ***
// Fault detection, flags and interrupt request for a LIN transceiver,
// with an Avalon-MM register slave. Assumes all inputs synchronous to clk.
//
// Behaviour
// - Factory test register always readable, writable only in special mode.
// - Status register is read-only; writes are ignored.
// - Status bit 7 is 1 while transmit input stays dominant after timeout.
// - While stuck dominant, transmitter stays off and timeout flag re-sets.
// - Interrupt enable register is readable and writable at any time.
// - Timeout flag with enable bit 7 raises the interrupt request.
// - Overcurrent flag with enable bit 6 raises the interrupt request.
// - Flags readable; writing 1 clears a flag, writing 0 does nothing.
// - Input still dominant after timeout limit sets flag 7, disables transmitter.
// - Clearing timeout flag while still dominant keeps transmitter off, re-sets flag.
// - Overcurrent sets flag 6 and disables the transmitter.
// - Clearing overcurrent flag during fault or dominant input re-sets it.
// - Both requests merge into one interrupt line.
// - Overcurrent inside the mask window after a falling edge only limits current.
// - Overcurrent clear needs one quiet bit time before transmitter returns.
`default_nettype none

module lpf_fault_irq
   import lpf_pkg::*;
#(
   parameter int unsigned DOM_LIMIT = DOM_TIMEOUT_CYC  // Dominant timeout in cycles
) (
   input  wire logic        clk,               // 50 MHz system clock
   input  wire logic        reset,             // Synchronous reset, active high
   input  wire logic        ce,                // Clock enable, freezes all state
   input  wire logic [4:0]  address,           // Avalon byte address
   input  wire logic        read,              // Avalon read request
   input  wire logic        write,             // Avalon write request
   input  wire logic [31:0] writedata,         // Avalon write data
   input  wire logic [3:0]  byteenable,        // Avalon byte lanes
   output logic [31:0]      readdata,          // Avalon read data
   output logic             waitrequest,       // Avalon stall
   input  wire logic        specialMode,       // Chip in special test mode
   input  wire logic        phyTransmitInput,  // Transmit input, 0 is dominant
   input  wire logic        overcurrentDetect, // Driver overcurrent comparator
   output logic             txDisable,         // Transmitter shut down
   output logic             currentLimit,      // Driver current limiting active
   output logic [7:0]       factoryTestBits,   // Factory test register contents
   output logic             phyCombinedIrq     // Level interrupt request
);

   lpf_bus_state_e busState_q;
   logic [31:0]    readdata_q;
   logic [7:0]     test_q;
   logic [1:0]     irqEn_q;           // [1] timeout, [0] overcurrent
   logic           enable_q;
   logic           rxOnly_q;
   logic           domFlag_q;
   logic           ocFlag_q;
   logic           stuck_q;
   logic           domDone_q;
   logic           request;
   logic           wrAcc;
   logic           domClr;
   logic           ocClr;
   logic           monitorActive;
   logic           domDone;
   logic           maskDone;
   logic           quietOk;
   logic           domExpire;
   logic           inMask;
   logic           ocEvent;
   logic           domSet;
   logic           ocSet;
   logic [7:0]     readMux;

   // Bus handshake: one stall cycle, answer on the second
   assign request     = read || write;
   assign waitrequest = request && (busState_q == BUS_IDLE || !ce);
   assign wrAcc       = write && busState_q == BUS_ANSWER && ce && byteenable[0];
   assign readdata    = readdata_q;

   // Flag clears, from the W1C flag register or its write-only alias
   assign domClr = wrAcc && (address == OFS_FLAGS || address == OFS_FLAG_CLR)
                   && writedata[BIT_DOM];
   assign ocClr  = wrAcc && (address == OFS_FLAGS || address == OFS_FLAG_CLR)
                   && writedata[BIT_OC];

   // Bus state
   always_ff @(posedge clk) begin
      if (reset) begin
         busState_q <= BUS_IDLE;
      end else if (ce) begin
         unique case (busState_q)
            BUS_IDLE: begin
               if (request) begin
                  busState_q <= BUS_ANSWER;
               end
            end
            BUS_ANSWER: begin
               busState_q <= BUS_IDLE;
            end
         endcase
      end
   end

   // Read mux; unmapped and write-only offsets read as zero
   always_comb begin
      readMux = 8'h00;
      unique case (address)
         OFS_TEST:   readMux = test_q;
         OFS_STATUS: readMux[BIT_DOM] = stuck_q;
         OFS_IRQ_EN: readMux[BIT_DOM:BIT_OC] = irqEn_q;
         OFS_FLAGS:  readMux[BIT_DOM:BIT_OC] = {domFlag_q, ocFlag_q};
         OFS_CTRL: begin
            readMux[BIT_ENABLE] = enable_q;
            readMux[BIT_RXONLY] = rxOnly_q;
         end
         default:    readMux = 8'h00;
      endcase
   end

   // Read data is captured in the stall cycle so it stands at the answer edge
   always_ff @(posedge clk) begin
      if (reset) begin
         readdata_q <= 32'h00000000;
      end else if (ce && busState_q == BUS_IDLE && read) begin
         readdata_q <= {24'h000000, readMux};
      end
   end

   // Factory test register; status has no write path at all
   always_ff @(posedge clk) begin
      if (reset) begin
         test_q <= TEST_RST;
      end else if (wrAcc && address == OFS_TEST && specialMode) begin
         test_q <= writedata[7:0];
      end
   end
   assign factoryTestBits = test_q;

   // Interrupt enables and unit control
   always_ff @(posedge clk) begin
      if (reset) begin
         irqEn_q  <= IRQ_EN_RST;
         enable_q <= ENABLE_RST;
         rxOnly_q <= RXONLY_RST;
      end else if (wrAcc) begin
         if (address == OFS_IRQ_EN) begin
            irqEn_q <= writedata[BIT_DOM:BIT_OC];
         end
         if (address == OFS_CTRL) begin
            enable_q <= writedata[BIT_ENABLE];
            rxOnly_q <= writedata[BIT_RXONLY];
         end
      end
   end

   // Transmit input is watched only while the unit may actually transmit
   assign monitorActive = enable_q && !rxOnly_q;

   lpf_cycle_timer #(.LIMIT(DOM_LIMIT)) u_domTimer (
      .clk   (clk),
      .reset (reset),
      .ce    (ce),
      .run   (monitorActive && !phyTransmitInput),
      .done  (domDone)
   );

   lpf_cycle_timer #(.LIMIT(OC_MASK_CYC)) u_maskTimer (
      .clk   (clk),
      .reset (reset),
      .ce    (ce),
      .run   (!phyTransmitInput),
      .done  (maskDone)
   );

   // Quiet time: no overcurrent and input recessive or unit not transmitting
   lpf_cycle_timer #(.LIMIT(BIT_TIME_CYC)) u_quietTimer (
      .clk   (clk),
      .reset (reset),
      .ce    (ce),
      .run   (!overcurrentDetect && (phyTransmitInput || !monitorActive)),
      .done  (quietOk)
   );

   // Edge of timeout expiry, so a long fault counts once
   always_ff @(posedge clk) begin
      if (reset) begin
         domDone_q <= 1'b0;
      end else if (ce) begin
         domDone_q <= domDone;
      end
   end
   assign domExpire = domDone && !domDone_q;

   // Stuck-dominant status: held until the input returns recessive
   always_ff @(posedge clk) begin
      if (reset) begin
         stuck_q <= 1'b0;
      end else if (ce) begin
         if (phyTransmitInput) begin
            stuck_q <= 1'b0;
         end else if (domExpire) begin
            stuck_q <= 1'b1;
         end
      end
   end

   // Stuck status keeps re-setting the flag, so a clear cannot stick
   assign domSet = domExpire || stuck_q;

   // Timeout flag; set wins over a simultaneous clear
   always_ff @(posedge clk) begin
      if (reset) begin
         domFlag_q <= 1'b0;
      end else if (ce) begin
         if (domSet) begin
            domFlag_q <= 1'b1;
         end else if (domClr) begin
            domFlag_q <= 1'b0;
         end
      end
   end

   // Overcurrent just after a falling edge is the bus discharging, not a fault
   assign inMask  = !phyTransmitInput && !maskDone;
   assign ocEvent = overcurrentDetect && !inMask && monitorActive;
   // A clear before a full quiet bit time is refused by setting again
   assign ocSet   = ocEvent || (ocClr && !quietOk);

   // Overcurrent flag; set wins over a simultaneous clear
   always_ff @(posedge clk) begin
      if (reset) begin
         ocFlag_q <= 1'b0;
      end else if (ce) begin
         if (ocSet) begin
            ocFlag_q <= 1'b1;
         end else if (ocClr) begin
            ocFlag_q <= 1'b0;
         end
      end
   end

   // Driver control and interrupt; the limiter acts even inside the mask
   assign txDisable      = domFlag_q || stuck_q || ocFlag_q;
   assign currentLimit   = overcurrentDetect;
   assign phyCombinedIrq = (domFlag_q && irqEn_q[1])
                        || (ocFlag_q && irqEn_q[0]);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_test_write_guard: assert property (
      (wrAcc && address == OFS_TEST && !specialMode) |=> $stable(test_q))
      else $error("test register changed outside special mode");

   a_status_read_only: assert property (
      (wrAcc && address == OFS_STATUS && !domExpire && !phyTransmitInput && ce)
      |=> stuck_q == $past(stuck_q))
      else $error("status write altered stuck status");

   a_stuck_clears: assert property (
      (ce && stuck_q && phyTransmitInput) |=> !stuck_q)
      else $error("stuck status did not clear on recessive input");

   a_stuck_refire: assert property (
      (ce && stuck_q && !phyTransmitInput) |=> (domFlag_q && txDisable))
      else $error("timeout flag not held while stuck dominant");

   a_enable_write: assert property (
      (wrAcc && address == OFS_IRQ_EN) |=> irqEn_q == $past(writedata[BIT_DOM:BIT_OC]))
      else $error("interrupt enable write lost");

   a_dom_irq: assert property (
      (domFlag_q && irqEn_q[1]) |-> phyCombinedIrq)
      else $error("timeout interrupt missing");

   a_oc_irq: assert property (
      (ocFlag_q && irqEn_q[0]) |-> phyCombinedIrq)
      else $error("overcurrent interrupt missing");

   a_irq_quiet: assert property (
      !((domFlag_q && irqEn_q[1]) || (ocFlag_q && irqEn_q[0])) |-> !phyCombinedIrq)
      else $error("interrupt raised without enabled flag");

   a_zero_write_keeps: assert property (
      (wrAcc && address == OFS_FLAGS && !writedata[BIT_DOM] && domFlag_q) |=> domFlag_q)
      else $error("writing zero cleared the timeout flag");

   a_timeout_sets: assert property (
      (ce && domExpire) |=> (domFlag_q && stuck_q && txDisable))
      else $error("timeout expiry did not set flag");

   a_oc_sets: assert property (
      (ce && ocEvent) |=> (ocFlag_q && txDisable))
      else $error("overcurrent did not set flag");

   a_mask_window: assert property (
      (ce && inMask && !ocFlag_q && !ocClr) |=> !ocFlag_q)
      else $error("masked overcurrent set the flag");

   a_early_clear: assert property (
      (ce && ocClr && !quietOk) |=> ocFlag_q[*2])
      else $error("overcurrent cleared before quiet bit time");

   a_set_wins: assert property (
      (ce && domSet && domClr) |=> domFlag_q)
      else $error("clear beat a simultaneous set");

   a_dom_clear_ok: assert property (
      (ce && domClr && !domSet) |=> !domFlag_q)
      else $error("timeout flag clear had no effect");

   a_oc_clear_ok: assert property (
      (ce && ocClr && !ocSet) |=> !ocFlag_q)
      else $error("overcurrent flag clear had no effect");

   a_test_write_takes: assert property (
      (wrAcc && address == OFS_TEST && specialMode) |=> test_q == $past(writedata[7:0]))
      else $error("special mode test write lost");

   a_flags_readback: assert property (
      (ce && busState_q == BUS_IDLE && read && address == OFS_FLAGS)
      |=> readdata == {24'h000000, $past(domFlag_q), $past(ocFlag_q), 6'h00})
      else $error("flag read returned wrong value");

   a_status_readback: assert property (
      (ce && busState_q == BUS_IDLE && read && address == OFS_STATUS)
      |=> readdata == {24'h000000, $past(stuck_q), 7'h00})
      else $error("status read returned wrong value");

   a_no_monitor: assert property (
      (ce && !monitorActive && !stuck_q && !domFlag_q) |=> !domFlag_q)
      else $error("timeout flagged while monitoring is off");

   a_bus_one_stall: assert property (
      (ce && request && busState_q == BUS_IDLE) ##1 (ce && request) |-> !waitrequest)
      else $error("bus answer missing after one stall cycle");

   a_ce_freeze: assert property (
      !ce |=> ($stable(domFlag_q) && $stable(ocFlag_q) && $stable(stuck_q)
               && $stable(irqEn_q) && $stable(test_q) && $stable(readdata)))
      else $error("state changed while clock enable was low");

endmodule

`default_nettype wire

// *** test/lpf_sci_model.sv ***
// Partner model: serial controller that drives the transceiver transmit input.
// Assumes one clock; the bench asks for a frame or a held dominant level.
`default_nettype none

module lpf_sci_model #(
   parameter int BITC = 100  // Cycles per bit
) (
   input  wire logic       clk,     // System clock
   input  wire logic       holdLow, // Hold the line dominant
   input  wire logic       start,   // Begin a frame, one cycle
   input  wire logic [7:0] txByte,  // Byte to send
   output logic            txd      // Transmit input, 0 is dominant
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [9:0] shift_q = 10'h3FF;
   int         bits_q = 0;
   int         cnt_q = 0;

   // Start bit, byte LSB first, stop bit; a busy frame ignores a new start
   always_ff @(posedge clk) begin
      if (start && bits_q == 0) begin
         shift_q <= {1'b1, txByte, 1'b0};
         bits_q  <= 10;
         cnt_q   <= BITC - 1;
      end else if (bits_q != 0) begin
         if (cnt_q == 0) begin
            shift_q <= {1'b1, shift_q[9:1]};
            bits_q  <= bits_q - 1;
            cnt_q   <= BITC - 1;
         end else begin
            cnt_q <= cnt_q - 1;
         end
      end
   end

   // Idle line rests recessive, as a real controller leaves it
   assign txd = holdLow ? 1'b0 : (bits_q != 0) ? shift_q[0] : 1'b1;
endmodule

`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the transceiver fault and interrupt block.
// Assumes the serial controller model drives the transmit input.
`default_nettype none

module tb;
   import lpf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int DOM = 2000;  // Shortened timeout, still longer than the mask
   typedef struct packed {
      logic       wr;
      logic [4:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } lpf_row_s;
   localparam lpf_row_s ROWS [10] = '{
      '{1'b1, OFS_STATUS, 8'hFF, 8'h00}, '{1'b0, OFS_STATUS, 8'h00, 8'h00},
      '{1'b1, OFS_IRQ_EN, 8'hC0, 8'h00}, '{1'b0, OFS_IRQ_EN, 8'h00, 8'hC0},
      '{1'b1, OFS_TEST, 8'h5A, 8'h00}, '{1'b0, OFS_TEST, 8'h00, 8'h00},
      '{1'b1, 5'h18, 8'hFF, 8'h00}, '{1'b0, 5'h18, 8'h00, 8'h00},
      '{1'b0, OFS_FLAG_CLR, 8'h00, 8'h00}, '{1'b0, OFS_FLAGS, 8'h00, 8'h00}
   };

   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        ce = 1'b1;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0]  byteenable = 4'hF;
   logic        specialMode = 1'b0;
   logic        overcurrentDetect = 1'b0;
   logic        holdLow = 1'b0;
   logic        start = 1'b0;
   logic [7:0]  txByte = 8'h00;
   logic [31:0] readdata, q;
   logic        waitrequest, txd, txDisable, currentLimit, phyCombinedIrq;
   logic [7:0]  factoryTestBits;
   int          failures = 0;
   int          nTests = 0;

   always #10 clk = ~clk;

   lpf_sci_model u_sci (.clk(clk), .holdLow(holdLow), .start(start), .txByte(txByte),
                        .txd(txd));

   lpf_fault_irq #(.DOM_LIMIT(DOM)) u_dut (
      .clk(clk), .reset(reset), .ce(ce), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .specialMode(specialMode),
      .phyTransmitInput(txd), .overcurrentDetect(overcurrentDetect),
      .txDisable(txDisable), .currentLimit(currentLimit),
      .factoryTestBits(factoryTestBits), .phyCombinedIrq(phyCombinedIrq));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask

   // Request holds until waitrequest is seen low at an edge, then drops
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      address   <= a;
      writedata <= {24'h0, d};
      read      <= !w;
      write     <= w;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n == 20) failures++;
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask

   task automatic summarize();
      if (failures == 0 && nTests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence: table rows first, then the fault cases
   initial begin
      cyc(12);
      reset <= 1'b0;
      cyc(1);
      chk({txDisable, phyCombinedIrq, factoryTestBits}, 32'h0);
      foreach (ROWS[i]) begin
         bus(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
         if (!ROWS[i].wr) chk(q, {24'h0, ROWS[i].e});
      end
      specialMode <= 1'b1;
      wr(OFS_TEST, 8'hA5);
      specialMode <= 1'b0;
      chk(factoryTestBits, 8'hA5);
      wr(OFS_TEST, 8'h3C);
      rd(OFS_TEST, 8'hA5);
      // Legal frame: long zero runs stay below the timeout
      wr(OFS_CTRL, 8'h08);
      start <= 1'b1;
      cyc(1);
      start <= 1'b0;
      cyc(1100);
      rd(OFS_FLAGS, 8'h00);
      // Stuck dominant input
      holdLow <= 1'b1;
      cyc(DOM + 5);
      chk({txDisable, phyCombinedIrq}, 2'b11);
      rd(OFS_FLAGS, 8'h80);
      rd(OFS_STATUS, 8'h80);
      wr(OFS_STATUS, 8'h00);
      rd(OFS_STATUS, 8'h80);
      wr(OFS_FLAGS, 8'h80);
      rd(OFS_FLAGS, 8'h80);
      chk(txDisable, 1'b1);
      wr(OFS_IRQ_EN, 8'h40);
      chk(phyCombinedIrq, 1'b0);
      holdLow <= 1'b0;
      cyc(2);
      rd(OFS_STATUS, 8'h00);
      wr(OFS_FLAGS, 8'h00);
      rd(OFS_FLAGS, 8'h80);
      wr(OFS_FLAG_CLR, 8'h80);
      rd(OFS_FLAGS, 8'h00);
      chk(txDisable, 1'b0);
      // Overcurrent inside, then outside the mask window
      holdLow <= 1'b1;
      cyc(10);
      overcurrentDetect <= 1'b1;
      cyc(2);
      chk({currentLimit, txDisable}, 2'b10);
      rd(OFS_FLAGS, 8'h00);
      overcurrentDetect <= 1'b0;
      cyc(OC_MASK_CYC);
      overcurrentDetect <= 1'b1;
      cyc(3);
      chk({txDisable, phyCombinedIrq}, 2'b11);
      holdLow <= 1'b0;
      rd(OFS_FLAGS, 8'h40);
      wr(OFS_FLAGS, 8'h40);
      rd(OFS_FLAGS, 8'h40);
      overcurrentDetect <= 1'b0;
      cyc(2);
      wr(OFS_FLAGS, 8'h40);
      rd(OFS_FLAGS, 8'h40);
      cyc(BIT_TIME_CYC + 10);
      wr(OFS_FLAGS, 8'h40);
      rd(OFS_FLAGS, 8'h00);
      chk({txDisable, phyCombinedIrq}, 2'b00);
      // Clock enable low: the read stalls and a long dominant level is not timed
      ce      <= 1'b0;
      holdLow <= 1'b1;
      address <= OFS_FLAGS;
      read    <= 1'b1;
      cyc(DOM + 5);
      chk({waitrequest, txDisable}, 2'b10);
      ce      <= 1'b1;
      holdLow <= 1'b0;
      rd(OFS_FLAGS, 8'h00);
      // Receive-only mode does not watch the transmit input
      wr(OFS_CTRL, 8'h0C);
      rd(OFS_CTRL, 8'h0C);
      holdLow <= 1'b1;
      cyc(DOM + 5);
      rd(OFS_FLAGS, 8'h00);
      chk(txDisable, 1'b0);
      holdLow <= 1'b0;
      // Byte lane 0 off ignores a write; then a mid-run reset clears everything
      wr(OFS_CTRL, 8'h08);
      wr(OFS_IRQ_EN, 8'hC0);
      byteenable <= 4'hE;
      wr(OFS_IRQ_EN, 8'h00);
      byteenable <= 4'hF;
      rd(OFS_IRQ_EN, 8'hC0);
      overcurrentDetect <= 1'b1;
      cyc(2);
      chk({txDisable, phyCombinedIrq}, 2'b11);
      reset <= 1'b1;
      cyc(2);
      reset             <= 1'b0;
      overcurrentDetect <= 1'b0;
      cyc(1);
      chk({txDisable, phyCombinedIrq}, 2'b00);
      rd(OFS_IRQ_EN, 8'h00);
      rd(OFS_FLAGS, 8'h00);
      summarize();
   end

   // Watchdog, well beyond the roughly 10650 cycles the tests need
   initial begin
      cyc(30000);
      failures++;
      summarize();
   end
endmodule

`default_nettype wire
